// file: design/hpb_defs.svh
// constants for the host parallel bus access block
// How it works
// [R01] host waits 135 ns after fifo reads before reading fifo info registers
// [R02] host leaves 180 ns between two drop counter reads
// [R03] host waits 45 ns after fabric data read before fabric command read
// [R04] host waits 45 ns between virtual phy expansion register reads
// [R05] waits may be met by dummy test register reads or elapsed time
// [R06] device serves register and fifo reads, 32-bit data, dword address decode
// [R07] read cycle starts with select and read strobe low, ends when either rises
// [R08] host keeps select or read strobe high for recovery between reads
// [R09] burst read gives fresh word on each address bit 2 toggle, up to 8
// [R10] host bursts only on the receive data fifo
// [R11] host keeps select or read strobe high for recovery between bursts
// [R12] fifo direct select high: only address bit 2 decoded, reads rx data fifo
// [R13] fifo direct burst: unlimited reads, new word per address bit 2 toggle
// [R14] host drives fifo select and endian select with address timing
// [R15] write cycle starts with select and write strobe low, ends when either rises
// [R16] host keeps select or write strobe high for recovery between writes
// [R17] side-effect reads update dependent status only after a delay
// [R18] strobes synchronised, one internal access per detected cycle start
`ifndef HPB_DEFS_SVH
`define HPB_DEFS_SVH
`define HPB_ADDR_W        8
`define HPB_DATA_W        32
`define HPB_CLK_PERIOD_NS 10
`define HPB_BURST_MAX     4'h8
// dword index of the receive data fifo port in the normal map
`define HPB_RX_DATA_IDX   8'h00
// side-effect status settles this long after a fifo pop
`define HPB_SETTLE_NS     135
`define HPB_SETTLE_CYC    ((`HPB_SETTLE_NS + `HPB_CLK_PERIOD_NS - 1) / `HPB_CLK_PERIOD_NS)
`endif

// file: design/hpb_host_port.sv
// host programmed i/o port: strobe synchroniser, access generation, read data path
`include "hpb_defs.svh"
module hpb_host_port (
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	input  wire logic                    host_select_n,
	input  wire logic                    host_read_strobe_n,
	input  wire logic                    host_write_strobe_n,
	input  wire logic                    fifo_sel,
	input  wire logic                    end_sel,
	input  wire logic [`HPB_ADDR_W-1:0]  host_addr,
	input  wire logic [`HPB_DATA_W-1:0]  host_wdata,
	output logic      [`HPB_DATA_W-1:0]  host_rdata,
	output logic                         host_rdata_oe,
	output logic                         reg_rd,
	output logic                         reg_wr,
	output logic      [`HPB_ADDR_W-1:0]  reg_addr,
	output logic      [`HPB_DATA_W-1:0]  reg_wdata,
	input  wire logic [`HPB_DATA_W-1:0]  reg_rdata,
	output logic                         rx_fifo_pop,
	input  wire logic [`HPB_DATA_W-1:0]  rx_fifo_data,
	output logic                         status_settling,
	output hpb_pkg::hpb_state_t          state
);
	import hpb_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// all pins pass two flops; address and data are stable while strobes are low, so
	// they are sampled in the second stage in step with the strobes [R14]
	logic [2:0]             strb_s1_r;
	logic [2:0]             strb_s2_r;
	logic [1:0]             sel_s1_r;
	logic [1:0]             sel_s2_r;
	logic [`HPB_ADDR_W-1:0] addr_s1_r;
	logic [`HPB_ADDR_W-1:0] addr_s2_r;
	logic [`HPB_DATA_W-1:0] wd_s1_r;
	logic [`HPB_DATA_W-1:0] wd_s2_r;

	// strobes idle high so reset cannot fake a cycle start
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			strb_s1_r <= 3'h7;
			strb_s2_r <= 3'h7;
		end else begin
			strb_s1_r <= {host_select_n, host_read_strobe_n, host_write_strobe_n}; // [R18]
			strb_s2_r <= strb_s1_r;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sel_s1_r <= 2'h0;
			sel_s2_r <= 2'h0;
		end else begin
			sel_s1_r <= {fifo_sel, end_sel};
			sel_s2_r <= sel_s1_r;
		end
	end

	// ----------------------------------------
	// address and data capture
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			addr_s1_r <= '0;
			addr_s2_r <= '0;
		end else begin
			addr_s1_r <= host_addr;
			addr_s2_r <= addr_s1_r;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wd_s1_r <= '0;
			wd_s2_r <= '0;
		end else begin
			wd_s1_r <= host_wdata;
			wd_s2_r <= wd_s1_r;
		end
	end

	// ----------------------------------------
	// cycle detection
	// ----------------------------------------
	// a cycle lives while select and its strobe are both low, in either order
	function automatic logic cycle_live(input logic sel_n, input logic strb_n);
		cycle_live = ~sel_n & ~strb_n;
	endfunction : cycle_live

	logic rd_act;
	logic wr_act;
	logic a2_s;
	assign rd_act = cycle_live(strb_s2_r[2], strb_s2_r[1]); // [R07]
	assign wr_act = cycle_live(strb_s2_r[2], strb_s2_r[0]); // [R15]
	assign a2_s   = addr_s2_r[0];

	function automatic logic [`HPB_DATA_W-1:0] swap_end(input logic [`HPB_DATA_W-1:0] d,
		input logic be);
		swap_end = be ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
	endfunction : swap_end

	// host_addr carries A[9:2]; bit 0 of it is address bit 2
	logic is_rx_fifo;
	// a burst toggles address bit 2, so the fifo port answers in both dword slots
	assign is_rx_fifo = sel_s2_r[1] |
		((addr_s2_r | 8'h01) == (`HPB_RX_DATA_IDX | 8'h01)); // [R12] [R09]

	// ----------------------------------------
	// cycle state
	// ----------------------------------------
	logic       a2_last_r;
	logic [3:0] burst_cnt_r;
	logic       direct_r;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state       <= HPB_IDLE;
			a2_last_r   <= 1'b0;
			burst_cnt_r <= 4'h0;
			direct_r    <= 1'b0;
		end else begin
			case (state)
				HPB_IDLE: begin
					if (rd_act) begin
						state       <= HPB_READ;
						a2_last_r   <= a2_s;
						burst_cnt_r <= 4'h1;
						direct_r    <= sel_s2_r[1];
					end else if (wr_act) begin
						state <= HPB_WRITE;
					end
				end
				HPB_READ: begin
					if (!rd_act) begin
						state <= HPB_IDLE; // [R07]
					end else if (a2_s != a2_last_r) begin
						a2_last_r <= a2_s; // [R09] [R13]
						// saturate: a long register burst must not wrap back under the limit
						if (burst_cnt_r != 4'hF) begin
							burst_cnt_r <= burst_cnt_r + 4'h1;
						end
					end
				end
				HPB_WRITE: begin
					if (!wr_act) begin
						state <= HPB_IDLE; // [R15]
					end
				end
				default: state <= HPB_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// access strobes and read data
	// ----------------------------------------
	logic rd_start;
	logic burst_step;
	logic burst_ok;
	assign rd_start   = (state == HPB_IDLE) & rd_act;
	// register bursts stop at the documented length; direct fifo bursts do not [R09] [R13]
	assign burst_ok   = direct_r | (burst_cnt_r < `HPB_BURST_MAX);
	assign burst_step = (state == HPB_READ) & rd_act & (a2_s != a2_last_r) & burst_ok;

	logic do_rd;
	assign do_rd = rd_start | burst_step;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rd      <= 1'b0;
			reg_wr      <= 1'b0;
			rx_fifo_pop <= 1'b0;
		end else begin
			reg_rd      <= do_rd & ~is_rx_fifo; // [R06] [R18]
			rx_fifo_pop <= do_rd & is_rx_fifo; // [R12] [R18]
			// write taken at the end of the cycle, when data has long settled
			reg_wr      <= (state == HPB_WRITE) & ~wr_act; // [R15] [R18]
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_addr <= '0;
		end else begin
			reg_addr <= sel_s2_r[1] ? `HPB_RX_DATA_IDX : addr_s2_r; // [R06]
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_wdata <= '0;
		end else if (state == HPB_WRITE) begin
			reg_wdata <= swap_end(wd_s2_r, sel_s2_r[0]);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			host_rdata    <= '0;
			host_rdata_oe <= 1'b0;
		end else begin
			host_rdata_oe <= rd_act;
			if (rx_fifo_pop) begin
				host_rdata <= swap_end(rx_fifo_data, sel_s2_r[0]);
			end else if (reg_rd) begin
				host_rdata <= swap_end(reg_rdata, sel_s2_r[0]); // [R06]
			end
		end
	end

	// ----------------------------------------
	// side-effect settling window
	// ----------------------------------------
	// a fifo pop updates dependent counts late; this flags the window in which
	// those counts may still read stale
	logic [7:0] settle_r;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			settle_r        <= 8'h00;
			status_settling <= 1'b0;
		end else begin
			if (rx_fifo_pop) begin
				settle_r <= 8'(`HPB_SETTLE_CYC); // [R17]
			end else if (settle_r != 8'h00) begin
				settle_r <= settle_r - 8'h01;
			end
			status_settling <= rx_fifo_pop | (settle_r > 8'h01); // [R17]
		end
	end
endmodule : hpb_host_port

// file: design/hpb_pkg.sv
// types for the host parallel bus access block
package hpb_pkg;
	typedef enum logic [1:0] {
		HPB_IDLE  = 2'b00,
		HPB_READ  = 2'b01,
		HPB_WRITE = 2'b10
	} hpb_state_t;
endpackage : hpb_pkg

// file: test/hpb_far_model.sv
// register file and receive fifo seen behind the host port
`include "hpb_defs.svh"
module hpb_far_model (
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire logic [`HPB_ADDR_W-1:0] reg_addr,
	input  wire logic                   rx_fifo_pop,
	output logic      [`HPB_DATA_W-1:0] reg_rdata,
	output logic      [`HPB_DATA_W-1:0] rx_fifo_data
);
	logic [15:0] cnt_r;
	// content tied to the index so a wrong decode shows up
	assign reg_rdata = {24'hA5A5A5, reg_addr};
	assign rx_fifo_data = {16'hC0DE, cnt_r};
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) cnt_r <= 16'h0000;
		else if (rx_fifo_pop) cnt_r <= cnt_r + 16'h0001;
	end
endmodule : hpb_far_model

// file: test/hpb_port_props.sv
// checker: timing relations on the host port outputs
`include "hpb_defs.svh"
module hpb_port_props (
	input wire logic                   sys_clk,
	input wire logic                   reset,
	input wire logic                   host_select_n,
	input wire logic                   end_sel,
	input wire logic [`HPB_DATA_W-1:0] host_rdata,
	input wire logic                   host_rdata_oe,
	input wire logic                   reg_rd,
	input wire logic                   reg_wr,
	input wire logic [`HPB_DATA_W-1:0] reg_rdata,
	input wire logic                   rx_fifo_pop,
	input wire logic [`HPB_DATA_W-1:0] rx_fifo_data,
	input wire logic                   status_settling
);
	import hpb_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	rd_pulse_a: assert property (reg_rd |=> !reg_rd) else $error("read pulse long");
	pop_pulse_a: assert property (rx_fifo_pop |=> !rx_fifo_pop) else $error("pop long");
	wr_pulse_a: assert property (reg_wr |=> !reg_wr) else $error("write pulse long");
	settle_on_a: assert property (rx_fifo_pop |-> ##[1:2] status_settling)
		else $error("no settle flag");
	idle_quiet_a: assert property (host_select_n [*6] |-> !host_rdata_oe && !reg_rd && !rx_fifo_pop)
		else $error("access while idle");
	wr_quiet_a: assert property (host_select_n [*8] |-> !reg_wr) else $error("late write");
	fifo_data_a: assert property (rx_fifo_pop && !end_sel |=> host_rdata == $past(rx_fifo_data))
		else $error("fifo data lost");
	reg_data_a: assert property (reg_rd && !end_sel |=> host_rdata == $past(reg_rdata))
		else $error("reg data lost");
endmodule : hpb_port_props
bind hpb_host_port hpb_port_props u_props (.*);

// file: test/hpb_tb.sv
// testbench for the host programmed i/o port
`include "hpb_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hpb_pkg::*;
	logic sys_clk = 0, reset = 1, host_select_n = 1, host_read_strobe_n = 1;
	logic host_write_strobe_n = 1, fifo_sel = 0, end_sel = 0;
	logic [7:0] host_addr = 8'h00, reg_addr, wa;
	logic [31:0] host_wdata = 32'h0, host_rdata, reg_wdata, reg_rdata, rx_fifo_data, wd;
	logic host_rdata_oe, reg_rd, reg_wr, rx_fifo_pop, status_settling;
	hpb_state_t state;
	int num_errors = 0, checks_done = 0, pops = 0, rds = 0, wrs = 0, p0, r0, w0;
	// register indices below are arbitrary picks for the far model
	localparam logic [7:0] info_idx = 8'h1F, drop_idx = 8'h20, fab_data_idx = 8'h2A;
	localparam logic [7:0] fab_cmd_idx = 8'h2B, vphy_exp_idx = 8'h3C;
	always #5 sys_clk = ~sys_clk;
	hpb_host_port dut (.sys_clk(sys_clk), .reset(reset), .host_select_n(host_select_n),
		.host_read_strobe_n(host_read_strobe_n), .host_write_strobe_n(host_write_strobe_n),
		.fifo_sel(fifo_sel), .end_sel(end_sel), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .rx_fifo_pop(rx_fifo_pop), .rx_fifo_data(rx_fifo_data),
		.status_settling(status_settling), .state(state));
	hpb_far_model u_far (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.rx_fifo_pop(rx_fifo_pop), .reg_rdata(reg_rdata), .rx_fifo_data(rx_fifo_data));
	always @(posedge sys_clk) begin
		pops += rx_fifo_pop;
		rds += reg_rd;
		wrs += reg_wr;
		if (reg_wr === 1'b1) begin
			wa = reg_addr;
			wd = reg_wdata;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one strobe cycle; toggles of address bit 2 while held ask for more words
	task automatic run(input logic fs, es, rd, input logic [7:0] a, input int tg,
		input logic [31:0] d);
		@(posedge sys_clk) #1;
		p0 = pops;
		r0 = rds;
		w0 = wrs;
		{fifo_sel, end_sel, host_addr, host_wdata, host_select_n} = {fs, es, a, d, 1'b0};
		if (rd) host_read_strobe_n = 0;
		else host_write_strobe_n = 0;
		repeat (6) @(posedge sys_clk);
		for (int i = 0; i < tg; i++) begin
			#1 host_addr[0] = ~host_addr[0];
			repeat (6) @(posedge sys_clk);
		end
		#1 {host_select_n, host_read_strobe_n, host_write_strobe_n} = 3'b111;
		repeat (10) @(posedge sys_clk);
	endtask : run
	task automatic reg_read_scn;
		run(0, 0, 1, 8'h05, 0, 32'h0);
		chk(rds - r0, 1);
		chk(pops - p0, 0);
		chk(host_rdata, 32'hA5A5A505);
	endtask : reg_read_scn
	task automatic write_scn;
		run(0, 0, 0, 8'h12, 0, 32'h1234ABCD);
		chk(wrs - w0, 1);
		chk(wa, 8'h12);
		chk(wd, 32'h1234ABCD);
	endtask : write_scn
	task automatic burst_scn;
		run(0, 0, 1, 8'h00, 9, 32'h0);
		chk(pops - p0, 8);
		chk(rds - r0, 0);
		chk(host_rdata, 32'hC0DE0007);
	endtask : burst_scn
	task automatic direct_scn;
		run(1, 1, 1, 8'hF9, 11, 32'h0);
		chk(pops - p0, 12);
		chk(rds - r0, 0);
		chk(host_rdata, 32'h1300DEC0);
		repeat (20) @(posedge sys_clk);
		chk(status_settling, 0);
	endtask : direct_scn
	task automatic settle_scn;
		int k = 0;
		int n = 0;
		@(posedge sys_clk) #1;
		{fifo_sel, end_sel, host_addr, host_select_n, host_read_strobe_n} = {2'b10, 8'h00, 2'b00};
		while (rx_fifo_pop !== 1'b1 && k < 10) begin
			@(posedge sys_clk) #1;
			k++;
		end
		chk(k < 10, 1);
		chk(host_rdata_oe, 1);
		chk(state, HPB_READ);
		@(posedge sys_clk) #1;
		while (status_settling === 1'b1 && n < 40) begin
			n++;
			@(posedge sys_clk) #1;
		end
		chk(n, `HPB_SETTLE_CYC);
		{host_select_n, host_read_strobe_n} = 2'b11;
		repeat (10) @(posedge sys_clk);
		#1;
		chk(host_rdata_oe, 0);
		chk(state, HPB_IDLE);
		run(0, 0, 1, info_idx, 0, 32'h0);
		chk(host_rdata, {24'hA5A5A5, info_idx});
	endtask : settle_scn
	task automatic spaced_scn;
		run(0, 0, 1, drop_idx, 0, 32'h0);
		repeat (8) @(posedge sys_clk);
		run(0, 0, 1, drop_idx, 0, 32'h0);
		chk(rds - r0, 1);
		run(0, 0, 1, fab_data_idx, 0, 32'h0);
		// the idle tail of run alone spans more than 45 ns
		run(0, 0, 1, fab_cmd_idx, 0, 32'h0);
		chk(host_rdata, {24'hA5A5A5, fab_cmd_idx});
		run(0, 0, 1, vphy_exp_idx, 0, 32'h0);
		run(0, 0, 1, vphy_exp_idx, 0, 32'h0);
		chk(host_rdata, {24'hA5A5A5, vphy_exp_idx});
	endtask : spaced_scn
	task automatic wrap_up;
		if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3) @(posedge sys_clk);
		#1 reset = 0;
		reg_read_scn();
		write_scn();
		burst_scn();
		direct_scn();
		settle_scn();
		spaced_scn();
		wrap_up();
	end
endmodule : tb
